// [rtl/adc_cal_pkg.sv]
// Constants for the calibration coefficient store and control register.
// Assumes a serial port on the same clock that walks register bytes.
// How it works
// - Upper or middle control write raises result_valid_n.
// - Such write in calibration mode recalibrates first.
// - Lone low control byte write starts nothing.
// - Offset register 24 bits, self-calibrated after reset.
// - Offset makes zero input give zero output.
// - Positive coefficient sets positive gain slope.
// - Negative coefficient sets negative gain slope.
// - Gain coefficients self-calibrated after reset.
// - result_valid_n low means result ready.
// - Gain field bits 7..5, reset unity.
// - Byte order bit picks descending or ascending.
package adc_cal_pkg;
  localparam int COEFF_W = 24;
  localparam int BYTE_W = 8;
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_OFFSET = 2'h1;
  localparam logic [1:0] SEL_POS_FS = 2'h2;
  localparam logic [1:0] SEL_NEG_FS = 2'h3;
  localparam logic [1:0] BYTE_LOW = 2'h0;
  localparam logic [1:0] BYTE_MID = 2'h1;
  localparam logic [1:0] BYTE_HIGH = 2'h2;
  localparam int MODE_LSB = 9;
  localparam int MODE_MSB = 11;
  localparam int BIPOLAR_BIT = 8;
  localparam int GAIN_LSB = 5;
  localparam int GAIN_MSB = 7;
  localparam int BYTE_ORDER_BIT = 2;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SELF_CAL = 3'h1;
  localparam logic [2:0] GAIN_UNITY = 3'h0;
  localparam logic [23:0] CONTROL_RESET =
    24'h000000 | (24'(MODE_SELF_CAL) << MODE_LSB) | (24'h000001 << BIPOLAR_BIT);
  localparam logic [23:0] COEFF_RESET = 24'h000000;
endpackage : adc_cal_pkg

// [rtl/byte_walker.sv]
// Byte pointer for one multi-byte register transfer.
// Assumes start and step are one-cycle pulses on clk.
`timescale 1ns/1ps
module byte_walker
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       ascending,
  input  wire logic       step,
  output logic      [1:0] byte_idx
);
  logic asc_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      byte_idx <= adc_cal_pkg::BYTE_HIGH;
      asc_reg  <= 1'b0;
    end
    else if (start)
    begin
      asc_reg  <= ascending;
      byte_idx <= ascending ? adc_cal_pkg::BYTE_LOW
                            : adc_cal_pkg::BYTE_HIGH;
    end
    else if (step)
    begin
      if (asc_reg)
        byte_idx <= (byte_idx == adc_cal_pkg::BYTE_HIGH)
                    ? adc_cal_pkg::BYTE_LOW : byte_idx + 2'h1;
      else
        byte_idx <= (byte_idx == adc_cal_pkg::BYTE_LOW)
                    ? adc_cal_pkg::BYTE_HIGH : byte_idx - 2'h1;
    end
  end
endmodule : byte_walker

// [rtl/adc_calibration_regs.sv]
// Calibration coefficient store, control register and data-ready logic.
// Assumes the serial port, filter and calibration engine share clk.
`timescale 1ns/1ps
module adc_calibration_regs
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        xfer_start,
  input  wire logic [1:0]  xfer_sel,
  input  wire logic        xfer_end,
  input  wire logic        byte_wr,
  input  wire logic        byte_rd,
  input  wire logic [7:0]  wr_byte,
  output logic      [7:0]  rd_byte,
  output logic      [1:0]  byte_idx,
  input  wire logic        conv_done,
  input  wire logic        result_read_done,
  output logic             cal_start,
  input  wire logic        cal_done,
  input  wire logic [23:0] cal_offset,
  input  wire logic [23:0] cal_pos_fs,
  input  wire logic [23:0] cal_neg_fs,
  output logic             result_valid_n,
  output logic             cal_busy,
  output logic      [23:0] control_word,
  output logic      [2:0]  gain_select,
  output logic             byte_order_select,
  output logic      [23:0] offset_coeff_bits,
  output logic      [23:0] pos_fullscale_coeff_bits,
  output logic      [23:0] neg_fullscale_coeff_bits
);
  logic [1:0]  sel_reg;
  logic        upper_written_reg;
  logic        cal_pending_reg;
  logic        ctrl_upper_wr;
  logic [7:0]  rd_next;
  logic [23:0] sel_word;
  logic [2:0]  mode_now;

  byte_walker u_walker
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .start     (xfer_start),
    .ascending (byte_order_select),
    .step      (byte_wr | byte_rd),
    .byte_idx  (byte_idx)
  );

  assign gain_select = control_word[adc_cal_pkg::GAIN_MSB:
                                    adc_cal_pkg::GAIN_LSB];
  assign byte_order_select = control_word[adc_cal_pkg::BYTE_ORDER_BIT];
  assign mode_now = control_word[adc_cal_pkg::MODE_MSB:
                                 adc_cal_pkg::MODE_LSB];
  assign ctrl_upper_wr = byte_wr && sel_reg == adc_cal_pkg::SEL_CONTROL
                         && byte_idx != adc_cal_pkg::BYTE_LOW;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sel_reg <= adc_cal_pkg::SEL_CONTROL;
    else if (xfer_start)
      sel_reg <= xfer_sel;
  end

  // Byte writes into the four registers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      control_word             <= adc_cal_pkg::CONTROL_RESET;
      offset_coeff_bits        <= adc_cal_pkg::COEFF_RESET;
      pos_fullscale_coeff_bits <= adc_cal_pkg::COEFF_RESET;
      neg_fullscale_coeff_bits <= adc_cal_pkg::COEFF_RESET;
    end
    else if (cal_done && cal_busy)
    begin
      offset_coeff_bits        <= cal_offset;
      pos_fullscale_coeff_bits <= cal_pos_fs;
      neg_fullscale_coeff_bits <= cal_neg_fs;
    end
    else if (byte_wr)
    begin
      case (sel_reg)
        adc_cal_pkg::SEL_CONTROL:
          control_word[byte_idx*8 +: 8] <= wr_byte;
        adc_cal_pkg::SEL_OFFSET:
          offset_coeff_bits[byte_idx*8 +: 8] <= wr_byte;
        adc_cal_pkg::SEL_POS_FS:
          pos_fullscale_coeff_bits[byte_idx*8 +: 8] <= wr_byte;
        adc_cal_pkg::SEL_NEG_FS:
          neg_fullscale_coeff_bits[byte_idx*8 +: 8] <= wr_byte;
        default:
          control_word <= control_word;
      endcase
    end
  end

  // Notes an upper or middle control byte written in this transfer.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      upper_written_reg <= 1'b0;
    else if (xfer_start || xfer_end)
      upper_written_reg <= 1'b0;
    else if (ctrl_upper_wr)
      upper_written_reg <= 1'b1;
  end

  // Calibration request after reset and after an upper control write outside normal mode.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cal_pending_reg <= 1'b1;
    else if (xfer_end && (upper_written_reg || ctrl_upper_wr)
             && mode_now != adc_cal_pkg::MODE_NORMAL)
      cal_pending_reg <= 1'b1;
    else if (cal_start)
      cal_pending_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cal_busy <= 1'b0;
    else if (cal_start)
      cal_busy <= 1'b1;
    else if (cal_done)
      cal_busy <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cal_start <= 1'b0;
    else
      cal_start <= cal_pending_reg && !cal_busy && !cal_start
                   && !xfer_start && sel_reg != adc_cal_pkg::SEL_CONTROL
                   || cal_pending_reg && !cal_busy && !cal_start
                   && !upper_written_reg;
  end

  // Active-low result indication.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      result_valid_n <= 1'b1;
    else if (ctrl_upper_wr)
      result_valid_n <= 1'b1;
    else if (cal_pending_reg || cal_busy)
      result_valid_n <= 1'b1;
    else if (conv_done)
      result_valid_n <= 1'b0;
    else if (result_read_done)
      result_valid_n <= 1'b1;
  end

  always_comb
  begin
    case (sel_reg)
      adc_cal_pkg::SEL_CONTROL: sel_word = control_word;
      adc_cal_pkg::SEL_OFFSET:  sel_word = offset_coeff_bits;
      adc_cal_pkg::SEL_POS_FS:  sel_word = pos_fullscale_coeff_bits;
      adc_cal_pkg::SEL_NEG_FS:  sel_word = neg_fullscale_coeff_bits;
      default:                  sel_word = control_word;
    endcase
    rd_next = (byte_idx == 2'h3) ? 8'h00 : sel_word[byte_idx*8 +: 8];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_byte <= 8'h00;
    else
      rd_byte <= rd_next;
  end
endmodule : adc_calibration_regs

// [dv/cal_engine_model.sv]
// Calibration engine model: answers cal_start after LAT cycles.
// Assumes it shares clk and rst_n with the register block.
`timescale 1ns/1ps
module cal_engine_model
#(
  parameter int          LAT = 6,
  parameter logic [23:0] OFS = 24'h000000,
  parameter logic [23:0] POS = 24'h000000,
  parameter logic [23:0] NEG = 24'h000000
)
(
  input  wire logic        clk, rst_n, cal_start,
  output logic             cal_done,
  output logic      [23:0] cal_offset, cal_pos_fs, cal_neg_fs
);
  int cnt;
  always_ff @(posedge clk)
    cnt <= !rst_n ? 0 : cal_start ? LAT : cnt > 0 ? cnt - 1 : 0;
  assign cal_done = cnt == 1;
  // Results are valid only with cal_done and inverted otherwise.
  assign cal_offset = cal_done ? OFS : ~OFS;
  assign cal_pos_fs = cal_done ? POS : ~POS;
  assign cal_neg_fs = cal_done ? NEG : ~NEG;
endmodule : cal_engine_model

// [dv/adc_calibration_regs_properties.sv]
// Checker for the calibration register block ports.
// Assumes xfer_sel stays put through each transfer.
`timescale 1ns/1ps
module adc_cal_chk
(
  input wire logic        clk, rst_n, byte_wr, conv_done, result_read_done,
  input wire logic        cal_start, cal_done, result_valid_n, cal_busy,
  input wire logic [1:0]  xfer_sel, byte_idx,
  input wire logic [7:0]  wr_byte,
  input wire logic [23:0] cal_offset, offset_coeff_bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_cal; cal_start ##1 cal_busy; endsequence
  sequence s_load; cal_done && cal_busy ##1
    offset_coeff_bits == $past(cal_offset); endsequence
  AST_UPPER_CTL: assert property (byte_wr && xfer_sel == 2'h0 &&
    byte_idx != 2'h0 |=> result_valid_n) else $error("ready not raised");
  AST_LOW_CTL: assert property (byte_wr && xfer_sel == 2'h0 &&
    byte_idx == 2'h0 && !conv_done && !result_read_done && !cal_start
    |=> $stable(result_valid_n)) else $error("ready moved");
  AST_FELL: assert property ($fell(result_valid_n) |->
    $past(conv_done)) else $error("ready without result");
  AST_RELEASE: assert property (result_read_done && !conv_done
    |=> result_valid_n) else $error("ready kept after read");
  AST_BUSY: assert property (cal_start |-> s_cal)
    else $error("no busy after start");
  AST_HOLD: assert property (cal_busy |-> result_valid_n)
    else $error("ready during calibration");
  AST_LOAD: assert property (cal_done && cal_busy |-> s_load)
    else $error("offset not loaded");
  AST_WR_HI: assert property (byte_wr && !cal_done &&
    xfer_sel == 2'h1 && byte_idx == 2'h2
    |=> offset_coeff_bits[23:16] == $past(wr_byte)) else $error("bad byte");
endmodule : adc_cal_chk
bind adc_calibration_regs adc_cal_chk chk(.clk, .rst_n, .byte_wr, .conv_done,
  .result_read_done, .cal_start, .cal_done, .result_valid_n, .cal_busy,
  .xfer_sel, .byte_idx, .wr_byte, .cal_offset, .offset_coeff_bits);

// [dv/test_adc_calibration_regs.sv]
// Bench for the calibration register block with an engine model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module test_adc_calibration_regs;
  localparam logic [23:0] OFS = 24'h13579B;
  localparam logic [23:0] POS = 24'h2468AC;
  localparam logic [23:0] NEG = 24'h7E5D3C;
  logic        clk = 0, rst_n = 0, xfer_start = 0, xfer_end = 0;
  logic        byte_wr = 0, byte_rd = 0, conv_done = 0, result_read_done = 0;
  logic        cal_start, cal_done, result_valid_n, cal_busy, bo;
  logic [1:0]  xfer_sel = 2'h0, byte_idx;
  logic [2:0]  gain;
  logic [7:0]  wr_byte = 8'h00, rd_byte;
  logic [23:0] cal_offset, cal_pos_fs, cal_neg_fs, ctl, ofs_q, pos_q, neg_q;
  logic [23:0] rv;
  int          n_fail = 0, num_checks = 0;
  always #25 clk = ~clk;
  adc_calibration_regs dut(.clk, .rst_n, .xfer_start, .xfer_sel, .xfer_end,
    .byte_wr, .byte_rd, .wr_byte, .rd_byte, .byte_idx, .conv_done,
    .result_read_done, .cal_start, .cal_done, .cal_offset, .cal_pos_fs,
    .cal_neg_fs, .result_valid_n, .cal_busy, .control_word(ctl),
    .gain_select(gain), .byte_order_select(bo), .offset_coeff_bits(ofs_q),
    .pos_fullscale_coeff_bits(pos_q), .neg_fullscale_coeff_bits(neg_q));
  cal_engine_model #(.LAT(6), .OFS(OFS), .POS(POS), .NEG(NEG)) eng(.clk,
    .rst_n, .cal_start, .cal_done, .cal_offset, .cal_pos_fs, .cal_neg_fs);
  task give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task tick;
    @(posedge clk);
    #5;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1;
    tick;
    s = 0;
  endtask : pulse
  task automatic xfer(input logic [1:0] s, int n, bit asc, logic [23:0] v);
    xfer_sel = s;
    pulse(xfer_start);
    for (int i = 0; i < n; i++)
    begin
      wr_byte = v[(asc ? i : 2 - i) * 8 +: 8];
      pulse(byte_wr);
      tick;
    end
    pulse(xfer_end);
  endtask : xfer
  // Reads three bytes; each byte stands one cycle after the pointer moves.
  task automatic read3(input logic [1:0] s, bit asc, output logic [23:0] v);
    xfer_sel = s;
    pulse(xfer_start);
    `CHK(byte_idx, asc ? 2'h0 : 2'h2)
    for (int i = 0; i < 3; i++)
    begin
      tick;
      v[(asc ? i : 2 - i) * 8 +: 8] = rd_byte;
      pulse(byte_rd);
    end
    pulse(xfer_end);
  endtask : read3
  task automatic wait_cal;
    int i, j;
    for (i = 0; i < 40 && cal_start !== 1'b1; i++) tick;
    tick;
    for (j = 0; j < 40 && cal_busy !== 1'b0; j++) tick;
    if (i == 40 || j == 40)
    begin
      n_fail++;
      give_verdict;
    end
    tick;
  endtask : wait_cal
  task t_reset;
    `CHK(ctl, 24'h000300)
    `CHK(result_valid_n, 1'b1)
    wait_cal;
    `CHK({ofs_q, pos_q, neg_q}, {OFS, POS, NEG})
    read3(2'h1, 0, rv);
    `CHK(rv, OFS)
  endtask : t_reset
  task t_regs;
    xfer(2'h0, 3, 0, 24'h000204);
    `CHK({bo, ctl}, {1'b1, 24'h000204})
    wait_cal;
    xfer(2'h1, 3, 1, 24'hA1B2C3);
    read3(2'h1, 1, rv);
    `CHK({ofs_q, rv}, {2{24'hA1B2C3}})
    xfer(2'h2, 3, 1, 24'h5A6B7C);
    xfer(2'h3, 3, 1, 24'h0F1E2D);
    `CHK({pos_q, neg_q}, {24'h5A6B7C, 24'h0F1E2D})
  endtask : t_regs
  task t_low;
    pulse(conv_done);
    tick;
    `CHK(result_valid_n, 1'b0)
    xfer(2'h0, 1, 1, 24'h0000A4);
    repeat (3) tick;
    `CHK({result_valid_n, cal_busy, gain, ofs_q}, {5'h05, 24'hA1B2C3})
  endtask : t_low
  task t_full;
    xfer(2'h0, 3, 1, 24'h0002A4);
    `CHK(result_valid_n, 1'b1)
    pulse(conv_done);
    wait_cal;
    `CHK({result_valid_n, ofs_q}, {1'b1, OFS})
    pulse(conv_done);
    tick;
    `CHK(result_valid_n, 1'b0)
    pulse(result_read_done);
    tick;
    `CHK(result_valid_n, 1'b1)
  endtask : t_full
  initial
  begin
    repeat (20) @(posedge clk);
    #5 rst_n = 1;
    t_reset;
    t_regs;
    t_low;
    t_full;
    give_verdict;
  end
endmodule : test_adc_calibration_regs
